// ---- asmc_checker.sv ----
// asmc_checker: pin protocol assertions for the sram host controller
`timescale 1ns/100ps
module asmc_checker
    import asmc_pkg::*;
#(
    parameter int RD_CYC = ASMC_RD_CYC,
    parameter int WR_CYC = ASMC_WR_CYC,
    parameter int GAP_CYC = ASMC_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // user side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire asmc_req_s req,
    input wire logic rsp_valid,
    input wire logic [ASMC_DATA_W-1:0] rsp_rdata,
    // memory pins
    input wire asmc_ctl_s mem_ctl,
    input wire logic [ASMC_ADDR_W-1:0] mem_addr,
    input wire logic [ASMC_DATA_W-1:0] mem_dq_i,
    input wire logic [ASMC_DATA_W-1:0] mem_dq_o,
    input wire logic [ASMC_DATA_W-1:0] mem_dq_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // decoded pin states
    wire sel = !mem_ctl.chip_select_low_n && mem_ctl.chip_select_high;
    wire lane_on = !(mem_ctl.upper_lane_sel_n && mem_ctl.lower_lane_sel_n);
    cs_pair_a: assert property (mem_ctl.chip_select_low_n != mem_ctl.chip_select_high)
        else $error("chip selects half asserted");
    wr_start_a: assert property (!mem_ctl.write_n |-> sel && lane_on && (&mem_dq_oe))
        else $error("write strobe without full selection");
    wr_len_a: assert property ($fell(mem_ctl.write_n) |-> ##WR_CYC $rose(mem_ctl.write_n))
        else $error("write strobe length wrong");
    wr_end_a: assert property ($rose(mem_ctl.write_n) |-> mem_ctl == ASMC_CTL_IDLE)
        else $error("write not ended by all controls");
    wr_hold_a: assert property ($rose(mem_ctl.write_n) |-> (&mem_dq_oe) && $stable(mem_dq_o))
        else $error("write data not held at end edge");
    rd_float_a: assert property (!mem_ctl.out_en_n |-> mem_dq_oe == '0 && mem_ctl.write_n)
        else $error("controller drives during read");
    rd_rsp_a: assert property ($fell(mem_ctl.out_en_n) |-> ##RD_CYC (rsp_valid && mem_ctl.out_en_n))
        else $error("read answer late or early");
    idle_rdy_a: assert property (req_ready |-> mem_ctl == ASMC_CTL_IDLE)
        else $error("ready while pins active");
    // main scenarios reached
    wr_c: cover property ($rose(mem_ctl.write_n));
    rd_c: cover property ($rose(mem_ctl.out_en_n));
    byte_c: cover property (!mem_ctl.out_en_n && mem_ctl.upper_lane_sel_n);
endmodule : asmc_checker

// ---- asmc_ctrl.sv ----
// asmc_ctrl: host side controller driving an asynchronous 16-bit static memory
`timescale 1ns/100ps
module asmc_ctrl
    import asmc_pkg::*;
#(
    parameter int RD_CYC = ASMC_RD_CYC,
    parameter int WR_CYC = ASMC_WR_CYC,
    parameter int GAP_CYC = ASMC_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire asmc_req_s req,
    // user response
    output logic rsp_valid,
    output logic [ASMC_DATA_W-1:0] rsp_rdata,
    // memory pins
    output asmc_ctl_s mem_ctl,
    output logic [ASMC_ADDR_W-1:0] mem_addr,
    input wire logic [ASMC_DATA_W-1:0] mem_dq_i,
    output logic [ASMC_DATA_W-1:0] mem_dq_o,
    output logic [ASMC_DATA_W-1:0] mem_dq_oe
);
    // ==========================================================
    // elaboration checks: every phase must fit the counter, and a read must outlast the two sync stages
    localparam int RD_MIN = 3; // two sync flops plus one cycle of settled data
    localparam int CNT_SPAN = 1 << ASMC_CNT_W;
    if (RD_CYC < RD_MIN || RD_CYC >= CNT_SPAN) begin : g_bad_rd
        $error("asmc_ctrl: RD_CYC out of range");
    end
    if (WR_CYC < 1 || WR_CYC >= CNT_SPAN) begin : g_bad_wr
        $error("asmc_ctrl: WR_CYC out of range");
    end
    if (GAP_CYC < 1 || GAP_CYC >= CNT_SPAN) begin : g_bad_gap
        $error("asmc_ctrl: GAP_CYC out of range");
    end

    // access phases; ST_WR_SET gives the address one cycle of setup before the strobe falls
    typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_SET, ST_WR, ST_GAP} asmc_state_e;

    // counter end points, cut to the counter width on purpose
    localparam logic [ASMC_CNT_W-1:0] RD_LAST = ASMC_CNT_W'(RD_CYC - 1);
    localparam logic [ASMC_CNT_W-1:0] WR_LAST = ASMC_CNT_W'(WR_CYC - 1);
    localparam logic [ASMC_CNT_W-1:0] GAP_LAST = ASMC_CNT_W'(GAP_CYC - 1);
    localparam logic [ASMC_CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [ASMC_CNT_W-1:0] CNT_ONE = ASMC_CNT_W'(1);

    // state, counter, pin and response registers
    asmc_state_e state_q, state_d;
    logic [ASMC_CNT_W-1:0] cnt_q, cnt_d;
    asmc_req_s cur_q;
    asmc_ctl_s ctl_q, ctl_d;
    logic dq_oe_q, dq_oe_d;
    logic [ASMC_DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic rsp_valid_q;
    logic [ASMC_DATA_W-1:0] rdata_q;

    // ==========================================================
    // decode of request and pin data
    wire take_req = (state_q == ST_IDLE) && req_valid && (req.lanes != 2'b00);
    wire cnt_done_rd = (cnt_q == RD_LAST);
    wire cnt_done_wr = (cnt_q == WR_LAST);
    wire cnt_done_gap = (cnt_q == GAP_LAST);
    // last cycle of each access; the response pulse follows these by one register
    wire rd_done = (state_q == ST_RD) && cnt_done_rd;
    wire wr_done = (state_q == ST_WR) && cnt_done_wr;
    wire [1:0] lane_sel_n;
    wire [ASMC_DATA_W-1:0] merged_rdata;

    asmc_lane_dec u_lane (
        .lanes(cur_q.lanes),
        .pin_data(dq_s2_q),
        .prev_data(rdata_q),
        .sel_n(lane_sel_n),
        .merged(merged_rdata)
    );

    // a request with no lanes would only put the memory in standby, so it is dropped at once
    assign req_ready = (state_q == ST_IDLE);

    // pins and response come straight from registers, so they never glitch
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign mem_ctl = ctl_q;
    assign mem_addr = cur_q.addr;
    assign mem_dq_o = cur_q.wdata;
    assign mem_dq_oe = {ASMC_DATA_W{dq_oe_q}};

    // ==========================================================
    // sequencer: all pin levels come from flops so selects are never mid-level or glitching
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + CNT_ONE;
        ctl_d = ctl_q;
        dq_oe_d = dq_oe_q;
        unique case (state_q)
            ST_IDLE: begin
                cnt_d = CNT_ZERO;
                ctl_d = ASMC_CTL_IDLE;
                dq_oe_d = 1'b0;
                if (take_req && !req.write) begin
                    // read: address and selects go out at one edge, the access time covers both
                    state_d = ST_RD;
                    ctl_d.chip_select_low_n = 1'b0;
                    ctl_d.chip_select_high = 1'b1;
                    ctl_d.out_en_n = 1'b0;
                    ctl_d.upper_lane_sel_n = ~req.lanes[1];
                    ctl_d.lower_lane_sel_n = ~req.lanes[0];
                end else if (take_req) begin
                    // address settles one cycle before any control goes active
                    state_d = ST_WR_SET;
                end
            end
            ST_RD: begin
                // data is sampled through two flops, so hold the access RD_CYC cycles
                if (cnt_done_rd) begin
                    state_d = ST_GAP;
                    cnt_d = CNT_ZERO;
                    ctl_d = ASMC_CTL_IDLE;
                end
            end
            ST_WR_SET: begin
                // output enable stays high so the memory is floating when data is driven
                state_d = ST_WR;
                cnt_d = CNT_ZERO;
                dq_oe_d = 1'b1;
                ctl_d.chip_select_low_n = 1'b0;
                ctl_d.chip_select_high = 1'b1;
                ctl_d.write_n = 1'b0;
                ctl_d.out_en_n = 1'b1;
                ctl_d.upper_lane_sel_n = lane_sel_n[1];
                ctl_d.lower_lane_sel_n = lane_sel_n[0];
            end
            ST_WR: begin
                // strobe, chip selects and lane selects all go inactive together to end the write; data stays driven one more cycle past them
                if (cnt_done_wr) begin
                    state_d = ST_GAP;
                    cnt_d = CNT_ZERO;
                    ctl_d = ASMC_CTL_IDLE;
                end
            end
            ST_GAP: begin
                // turnaround: the bus is released before the next access may start
                dq_oe_d = 1'b0;
                if (cnt_done_gap) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                ctl_d = ASMC_CTL_IDLE;
                dq_oe_d = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // state and pin flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            ctl_q <= ASMC_CTL_IDLE;
            dq_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ctl_q <= ctl_d;
            dq_oe_q <= dq_oe_d;
        end
    end

    // request capture; address and data are held stable for the whole access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_q <= '0;
        end else if (take_req) begin
            cur_q <= req;
        end
    end

    // pin data synchroniser: only the second stage is read, the first may be metastable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= mem_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // response pulse and word; unselected lanes keep the previous read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            rsp_valid_q <= rd_done || wr_done;
            if (rd_done) begin
                rdata_q <= merged_rdata;
            end
        end
    end
endmodule : asmc_ctrl

// ---- asmc_lane_dec.sv ----
// asmc_lane_dec: per-lane byte select decode and read data merge
`timescale 1ns/100ps
module asmc_lane_dec
    import asmc_pkg::*;
(
    // request lanes
    input wire logic [1:0] lanes,
    // captured pin data and previous read word
    input wire logic [ASMC_DATA_W-1:0] pin_data,
    input wire logic [ASMC_DATA_W-1:0] prev_data,
    // decoded selects and merged word
    output logic [1:0] sel_n,
    output logic [ASMC_DATA_W-1:0] merged
);
    // ==========================================================
    // one lane per generate pass; an unselected lane keeps old data since the device floats it
    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign sel_n[g] = ~lanes[g];
        assign merged[g*ASMC_LANE_W +: ASMC_LANE_W] = lanes[g] ?
            pin_data[g*ASMC_LANE_W +: ASMC_LANE_W] : prev_data[g*ASMC_LANE_W +: ASMC_LANE_W];
    end
endmodule : asmc_lane_dec

// ---- asmc_pkg.sv ----
// asmc_pkg: shared constants and carriers for the async sram host controller
package asmc_pkg;
    // ==========================================================
    // geometry
    localparam int ASMC_ADDR_W = 19;
    localparam int ASMC_DATA_W = 16;
    localparam int ASMC_LANE_W = 8;
    // ==========================================================
    // timing, ns, with derived cycle counts at 100 MHz
    localparam int ASMC_CLK_NS = 10;
    localparam int ASMC_T_AA_NS = 45;     // address to data valid, longest
    localparam int ASMC_T_PWE_NS = 35;    // write strobe pulse, least
    localparam int ASMC_T_SD_NS = 25;     // data setup to write end, least
    localparam int ASMC_T_HZWE_NS = 18;   // strobe low to high z, longest
    localparam int ASMC_T_LZWE_NS = 10;   // strobe high to low z, least
    localparam int ASMC_RD_CYC = (ASMC_T_AA_NS + ASMC_CLK_NS - 1) / ASMC_CLK_NS + 1;
    localparam int ASMC_WR_CYC_RAW = (ASMC_T_PWE_NS > ASMC_T_SD_NS + ASMC_T_HZWE_NS) ?
        ASMC_T_PWE_NS : ASMC_T_SD_NS + ASMC_T_HZWE_NS;
    localparam int ASMC_WR_CYC = (ASMC_WR_CYC_RAW + ASMC_CLK_NS - 1) / ASMC_CLK_NS;
    localparam int ASMC_GAP_CYC = (ASMC_T_LZWE_NS + ASMC_CLK_NS - 1) / ASMC_CLK_NS;
    localparam int ASMC_CNT_W = 4;
    // ==========================================================
    // pin carriers
    typedef struct packed {
        logic chip_select_low_n;
        logic chip_select_high;
        logic write_n;
        logic out_en_n;
        logic upper_lane_sel_n;
        logic lower_lane_sel_n;
    } asmc_ctl_s;
    localparam asmc_ctl_s ASMC_CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    typedef struct packed {
        logic write;
        logic [1:0] lanes;   // bit1 upper, bit0 lower
        logic [ASMC_ADDR_W-1:0] addr;
        logic [ASMC_DATA_W-1:0] wdata;
    } asmc_req_s;
endpackage : asmc_pkg

// ---- asmc_sram_model.sv ----
// asmc_sram_model: behavioural 16-bit async static memory at the pins
`timescale 1ns/100ps
module asmc_sram_model
    import asmc_pkg::*;
(
    // pattern clock and pins
    input wire logic clk,
    input wire asmc_ctl_s ctl,
    input wire logic [ASMC_ADDR_W-1:0] addr,
    input wire logic [ASMC_DATA_W-1:0] dq_o,
    input wire logic [ASMC_DATA_W-1:0] dq_oe,
    // resolved data wire
    output logic [ASMC_DATA_W-1:0] dq_i
);
    logic [ASMC_DATA_W-1:0] mem [0:15];
    logic tog = 1'b0;
    // selection and lane decode; both lanes off is standby
    wire sel = !ctl.chip_select_low_n && ctl.chip_select_high;
    wire up = sel && !ctl.upper_lane_sel_n;
    wire lo = sel && !ctl.lower_lane_sel_n;
    wire rd = ctl.write_n && !ctl.out_en_n;
    wire [ASMC_DATA_W-1:0] word = mem[addr[3:0]];
    wire [ASMC_DATA_W-1:0] flt = {8{tog, ~tog}};
    always @(posedge clk) tog <= ~tog;
    // level write: the value at the terminating edge is what stays
    always @* begin
        if (!ctl.write_n && up) mem[addr[3:0]][15:8] = dq_o[15:8];
        if (!ctl.write_n && lo) mem[addr[3:0]][7:0] = dq_o[7:0];
    end
    // floating lanes show a toggling pattern, never the old value
    assign dq_i[15:8] = dq_oe[15] ? dq_o[15:8] : (rd && up) ? word[15:8] : flt[15:8];
    assign dq_i[7:0] = dq_oe[0] ? dq_o[7:0] : (rd && lo) ? word[7:0] : flt[7:0];
endmodule : asmc_sram_model

// ---- tb_top.sv ----
// tb_top: directed testbench for the sram host controller
`timescale 1ns/100ps
module tb_top;
    import asmc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    asmc_req_s req = '0;
    logic req_ready, rsp_valid;
    logic [ASMC_DATA_W-1:0] rsp_rdata, dq_i, dq_o, dq_oe, last_rd = '0;
    logic [ASMC_DATA_W-1:0] exp_mem [0:15];
    asmc_ctl_s mem_ctl;
    logic [ASMC_ADDR_W-1:0] mem_addr;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    asmc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ctl(mem_ctl), .mem_addr(mem_addr),
        .mem_dq_i(dq_i), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe));
    asmc_sram_model u_mem (.clk(clk), .ctl(mem_ctl), .addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    task close_out;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one request with handshake, then a bounded wait for the answer
    task op(input logic wr, input logic [1:0] ln, input logic [3:0] a, input logic [15:0] d);
        logic got;
        got = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{wr, ln, {15'h0, a}, d};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(negedge clk);
            got = (rsp_valid === 1'b1);
        end
        if (wr && ln[1]) exp_mem[a][15:8] = d[15:8];
        if (wr && ln[0]) exp_mem[a][7:0] = d[7:0];
        if (!wr && ln[1]) last_rd[15:8] = exp_mem[a][15:8];
        if (!wr && ln[0]) last_rd[7:0] = exp_mem[a][7:0];
        check({15'h0, got}, {15'h0, ln != 2'b00});
        if (!wr) check(rsp_rdata, last_rd);
    endtask : op
    task t_reset;
        @(negedge clk);
        check({10'h0, mem_ctl}, {10'h0, ASMC_CTL_IDLE});
        check(dq_oe, 16'h0000);
        $display("t_reset done");
    endtask : t_reset
    // full, lower and upper writes each read back through their own lanes, then one full read
    task t_lanes;
        op(1'b1, 2'h3, 4'h1, 16'ha5c3);
        op(1'b0, 2'h3, 4'h1, 16'h0000);
        op(1'b1, 2'h1, 4'h1, 16'h1234);
        op(1'b0, 2'h1, 4'h1, 16'h0000);
        op(1'b1, 2'h2, 4'h1, 16'hbeef);
        op(1'b0, 2'h2, 4'h1, 16'h0000);
        op(1'b0, 2'h3, 4'h1, 16'h0000);
        $display("t_lanes done");
    endtask : t_lanes
    // no lane selected is dropped and stores nothing
    task t_null;
        op(1'b1, 2'h0, 4'h1, 16'h0f0f);
        op(1'b0, 2'h3, 4'h1, 16'h0000);
        $display("t_null done");
    endtask : t_null
    // neighbouring addresses keep their own words
    task t_addr;
        op(1'b1, 2'h3, 4'h2, 16'h5a96);
        op(1'b1, 2'h3, 4'h3, 16'h6b07);
        op(1'b0, 2'h3, 4'h2, 16'h0000);
        op(1'b0, 2'h3, 4'h3, 16'h0000);
        $display("t_addr done");
    endtask : t_addr
    // hang guard, well above the fewer than 200 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("[FAIL] t=%0t cycles=%h limit=%h", $time, cycles, 3000);
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_lanes();
        t_null();
        t_addr();
        close_out();
    end
endmodule : tb_top
bind asmc_ctrl asmc_checker #(.RD_CYC(RD_CYC), .WR_CYC(WR_CYC), .GAP_CYC(GAP_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_ctl(mem_ctl), .mem_addr(mem_addr), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
